// ### pcc_copper_regs.sv
// Paged copper control register bank behind an Avalon-MM slave
`timescale 1ns/1ns
`include "pcc_params.svh"

module pcc_copper_regs #(
	parameter logic [20:0] LD_10_CYC = 21'(`PCC_LD_10_MS * `PCC_CLK_KHZ), // 10 ms in cycles
	parameter logic [20:0] LD_20_CYC = 21'(`PCC_LD_20_MS * `PCC_CLK_KHZ), // 20 ms in cycles
	parameter logic [20:0] LD_40_CYC = 21'(`PCC_LD_40_MS * `PCC_CLK_KHZ), // 40 ms in cycles
	parameter logic DIS_1000_RST = 1'b0, // Gigabit disable after hardware reset
	parameter logic REV_AN_RST = 1'b0, // Reverse autoneg after hardware reset
	parameter logic DIS_100_RST = 1'b0 // 100 Mb disable after hardware reset
) (
	input wire logic clock_i, // 25 MHz clock
	input wire logic reset_n_i, // Synchronous reset, active low
	input wire logic [6:0] address_i, // Avalon byte address
	input wire logic read_i, // Avalon read
	input wire logic write_i, // Avalon write
	input wire logic [3:0] byteenable_i, // Avalon byte enables
	input wire logic [31:0] writedata_i, // Avalon write data
	output logic [31:0] readdata_o, // Avalon read data
	output logic waitrequest_o, // Avalon wait request
	output logic irq_o, // Level interrupt
	input wire logic false_carrier_i, // False carrier seen, one pulse each
	input wire logic symbol_error_i, // Symbol error seen, one pulse each
	input wire logic short_ipg_i, // Insufficient gap seen on 10/100
	input wire logic power_down_i, // Device in power-down
	input wire logic copper_link_up_i, // Copper link status
	input wire logic adv_1000_full_i, // Base page gigabit full advert
	input wire logic adv_1000_half_i, // Base page gigabit half advert
	input wire logic adv_100_full_i, // Base page 100 full advert
	input wire logic adv_100_half_i, // Base page 100 half advert
	input wire logic gig_fail_i, // Raw gigabit link failure
	input wire logic gig_down_std_i, // Standard gigabit link-down verdict
	output logic link_drop_o, // Drop link for short gap
	output logic tx_clk_local_o, // 100 Mb transmit clock is local
	output logic te_enable_o, // 10BASE-Te enable
	output logic accel_link_up_o, // Accelerate 100 Mb link-up
	output logic [3:0] tx_pol_invert_o, // Per-pair transmit inversion
	output logic adv_1000_o, // Advertise 1000BASE-T
	output logic adv_100_o, // Advertise 100BASE-TX
	output logic reverse_an_o, // Run reversed autonegotiation
	output logic an_restart_o, // Autonegotiation restart pulse
	output logic gig_link_down_o, // Gigabit link-down verdict
	output logic tx_class_a_o, // Gigabit transmitter class A
	output logic test_112_o, // Send 112 ns test sequence
	output logic test_16_o, // Send 16 ns test sequence
	output logic rx_pol_force_o, // Force negative receive polarity
	output logic [7:0] page_o // Current page number
);

	// ============================================================
	// Helpers

	// Merge low two byte lanes of a write into a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0])
		begin
			r[7:0] = wd[7:0];
		end
		if (be[1])
		begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	// ============================================================
	// Bus decode
	logic wait_q, wait_d; // Wait request state
	logic [31:0] rdata_q, rdata_d; // Read data register
	logic [4:0] idx; // Word index
	logic req; // Request pending
	logic do_wr; // Write takes effect this edge
	logic do_rd; // Read captured this edge
	logic on_page0; // Page zero selected

	assign idx = address_i[6:2];
	assign req = read_i | write_i;
	assign do_wr = write_i & ~wait_q;
	assign do_rd = read_i & wait_q;

	// ============================================================
	// Register state
	pcc_pkg::pcc_ctrl2_t ctrl2_q, ctrl2_d; // Copper control two
	pcc_pkg::pcc_ctrl3_t ctrl3_q, ctrl3_d; // Written copper control three
	logic [2:0] eff_q, eff_d; // Applied dis_1000, reverse_an, dis_100
	logic [15:0] rxerr_q, rxerr_d; // Receive error counter
	logic [15:0] page_q, page_d; // Page register
	logic [`PCC_IRQ_W-1:0] stat_q, stat_d; // Interrupt status
	logic [`PCC_IRQ_W-1:0] mask_q, mask_d; // Interrupt mask
	logic pd_q, pd_d; // Power-down seen last cycle
	logic an_rst_q, an_rst_d; // Restart pulse register
	logic sw_rst, an_rst, pd_wake, apply; // Command events
	logic rx_event; // Counter increment this cycle
	logic [`PCC_IRQ_W-1:0] ev; // Interrupt events

	assign on_page0 = (page_q[7:0] == `PCC_CTRL_PAGE);
	assign sw_rst = do_wr & (idx == `PCC_IDX_CMD) & byteenable_i[0]
		& writedata_i[`PCC_CMD_SWRST];
	assign an_rst = do_wr & (idx == `PCC_IDX_CMD) & byteenable_i[0]
		& writedata_i[`PCC_CMD_ANRST];
	assign pd_wake = pd_q & ~power_down_i & ~copper_link_up_i;
	assign apply = sw_rst | an_rst | pd_wake;
	assign rx_event = false_carrier_i | symbol_error_i;

	// Interrupt events: a saturation hit is reported once, on arrival at the top
	always_comb
	begin
		ev = '0;
		ev[`PCC_IRQ_FCAR] = false_carrier_i;
		ev[`PCC_IRQ_SYM] = symbol_error_i;
		ev[`PCC_IRQ_SAT] = (rxerr_d == `PCC_RXERR_MAX) & (rxerr_q != `PCC_RXERR_MAX);
	end

	// ============================================================
	// Bus handshake and read mux: one wait cycle, answer on the second edge
	always_comb
	begin
		wait_d = ~(req & wait_q);
		rdata_d = rdata_q;
		if (do_rd)
		begin
			rdata_d = '0;
			unique case (idx)
				// Page-zero registers read as zero from any other page
				`PCC_IDX_CTRL2: rdata_d[15:0] = on_page0 ? ctrl2_q : 16'h0000;
				`PCC_IDX_RXERR: rdata_d[15:0] = on_page0 ? rxerr_q : 16'h0000;
				`PCC_IDX_PAGE: rdata_d[15:0] = page_q;
				`PCC_IDX_CTRL3: rdata_d[15:0] = on_page0 ? ctrl3_q : 16'h0000;
				`PCC_IDX_IRQ_STAT: rdata_d[`PCC_IRQ_W-1:0] = stat_q;
				`PCC_IDX_IRQ_MASK: rdata_d[`PCC_IRQ_W-1:0] = mask_q;
				default: rdata_d = '0; // Unmapped reads as zero
			endcase
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!reset_n_i)
		begin
			wait_q <= 1'b1;
			rdata_q <= '0;
		end
		else
		begin
			wait_q <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// ============================================================
	// Control registers, counter and software reset
	always_comb
	begin
		ctrl2_d = ctrl2_q;
		ctrl3_d = ctrl3_q;
		eff_d = eff_q;
		page_d = page_q;
		mask_d = mask_q;
		pd_d = power_down_i;
		an_rst_d = an_rst;
		rxerr_d = rxerr_q;
		// Counter cleared when read, captured value already in read data
		if (do_rd & on_page0 & (idx == `PCC_IDX_RXERR))
		begin
			rxerr_d = '0;
		end
		// Increment wins over the read clear so no event is lost
		if (rx_event)
		begin
			if (rxerr_d != `PCC_RXERR_MAX)
			begin
				rxerr_d = rxerr_d + 16'h0001;
			end
		end
		if (do_wr)
		begin
			unique case (idx)
				`PCC_IDX_CTRL2:
				begin
					if (on_page0)
					begin
						ctrl2_d = merge16(ctrl2_q, writedata_i, byteenable_i);
					end
				end
				`PCC_IDX_CTRL3:
				begin
					if (on_page0)
					begin
						ctrl3_d = merge16(ctrl3_q, writedata_i, byteenable_i);
					end
				end
				`PCC_IDX_PAGE:
				begin
					// Bits 13:8 stay zero; top bits relied on being written zero
					page_d = merge16(page_q, writedata_i, byteenable_i)
						& `PCC_PAGE_WMASK;
				end
				`PCC_IDX_IRQ_MASK:
				begin
					if (byteenable_i[0])
					begin
						mask_d = writedata_i[`PCC_IRQ_W-1:0];
					end
				end
				default:
				begin
					ctrl2_d = ctrl2_q; // Others have no stored effect here
				end
			endcase
		end
		// Update fields return to hardware default, retain fields stay
		if (sw_rst)
		begin
			ctrl2_d.tx_clk_local = 1'(`PCC_CTRL2_RST >> `PCC_CTRL2_CLK_POS);
			ctrl3_d.rsvd = `PCC_CTRL3_RSVD_RST;
			page_d[13:8] = '0;
		end
		// Advertised and autoneg bits follow the written value only on events
		if (apply)
		begin
			eff_d = {ctrl3_d.dis_1000, ctrl3_d.reverse_an, ctrl3_d.dis_100};
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!reset_n_i)
		begin
			ctrl2_q <= `PCC_CTRL2_RST;
			ctrl3_q <= {1'b0, DIS_1000_RST, REV_AN_RST, DIS_100_RST, 12'h000};
			eff_q <= {DIS_1000_RST, REV_AN_RST, DIS_100_RST};
			rxerr_q <= '0;
			page_q <= '0;
			mask_q <= '0;
			pd_q <= 1'b0;
			an_rst_q <= 1'b0;
		end
		else
		begin
			ctrl2_q <= ctrl2_d;
			ctrl3_q <= ctrl3_d;
			eff_q <= eff_d;
			rxerr_q <= rxerr_d;
			page_q <= page_d;
			mask_q <= mask_d;
			pd_q <= pd_d;
			an_rst_q <= an_rst_d;
		end
	end

	// ============================================================
	// Interrupt status: sticky, write one to clear, new event wins
	logic irq_q, irq_d; // Interrupt output register

	always_comb
	begin
		stat_d = stat_q;
		if (do_wr & (idx == `PCC_IDX_IRQ_STAT) & byteenable_i[0])
		begin
			stat_d = stat_q & ~writedata_i[`PCC_IRQ_W-1:0];
		end
		stat_d = stat_d | ev;
		irq_d = |(stat_d & mask_d);
	end

	always_ff @(posedge clock_i)
	begin
		if (!reset_n_i)
		begin
			stat_q <= '0;
			irq_q <= 1'b0;
		end
		else
		begin
			stat_q <= stat_d;
			irq_q <= irq_d;
		end
	end

	// ============================================================
	// Gigabit link-down timer, meaningful only with the fast mode
	logic [20:0] ld_cnt_q, ld_cnt_d; // Cycles of continuous failure
	logic [20:0] ld_target; // Selected delay
	logic gdown_q, gdown_d; // Link-down verdict

	// Delay tolerance is generous, so exact cycle counts suffice
	always_comb
	begin
		unique case (ctrl3_q.ld_delay)
			2'b00: ld_target = '0;
			2'b01: ld_target = LD_10_CYC;
			2'b10: ld_target = LD_20_CYC;
			2'b11: ld_target = LD_40_CYC;
		endcase
	end

	always_comb
	begin
		ld_cnt_d = '0;
		if (gig_fail_i & (ld_cnt_q != ld_target))
		begin
			ld_cnt_d = ld_cnt_q + 21'h000001;
		end
		else if (gig_fail_i)
		begin
			ld_cnt_d = ld_cnt_q;
		end
		if (ctrl3_q.fast_ld)
		begin
			gdown_d = gig_fail_i & (ld_cnt_q == ld_target);
		end
		else
		begin
			gdown_d = gig_down_std_i;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!reset_n_i)
		begin
			ld_cnt_q <= '0;
			gdown_q <= 1'b0;
		end
		else
		begin
			ld_cnt_q <= ld_cnt_d;
			gdown_q <= gdown_d;
		end
	end

	// ============================================================
	// Registered feature outputs
	logic [14:0] feat_q, feat_d; // Packed feature outputs

	always_comb
	begin
		feat_d = '0;
		feat_d[0] = short_ipg_i & ~ctrl2_q.ipg_keep_link;
		feat_d[1] = ctrl2_q.tx_clk_local;
		feat_d[2] = ctrl2_q.te_enable;
		feat_d[3] = ctrl2_q.accel_link_up;
		feat_d[7:4] = ctrl2_q.tx_pol_invert;
		feat_d[8] = ~eff_q[2] & (adv_1000_full_i | adv_1000_half_i);
		feat_d[9] = ~eff_q[0] & (adv_100_full_i | adv_100_half_i);
		feat_d[10] = eff_q[1];
		feat_d[11] = ctrl3_q.tx_class_a;
		feat_d[12] = ctrl3_q.test_sel == 2'b10;
		feat_d[13] = ctrl3_q.test_sel == 2'b11;
		feat_d[14] = ctrl3_q.rx_pol_force;
	end

	always_ff @(posedge clock_i)
	begin
		if (!reset_n_i)
		begin
			feat_q <= '0;
		end
		else
		begin
			feat_q <= feat_d;
		end
	end

	// ============================================================
	// Output wiring, all from flip-flops
	assign readdata_o = rdata_q;
	assign waitrequest_o = wait_q;
	assign irq_o = irq_q;
	assign link_drop_o = feat_q[0];
	assign tx_clk_local_o = feat_q[1];
	assign te_enable_o = feat_q[2];
	assign accel_link_up_o = feat_q[3];
	assign tx_pol_invert_o = feat_q[7:4];
	assign adv_1000_o = feat_q[8];
	assign adv_100_o = feat_q[9];
	assign reverse_an_o = feat_q[10];
	assign tx_class_a_o = feat_q[11];
	assign test_112_o = feat_q[12];
	assign test_16_o = feat_q[13];
	assign rx_pol_force_o = feat_q[14];
	assign an_restart_o = an_rst_q;
	assign gig_link_down_o = gdown_q;
	assign page_o = page_q[7:0];

endmodule // pcc_copper_regs

// ### pcc_params.svh
// Constants for the paged copper control register bank
// Contract
// - Clear link-break bit drops link on short gaps
// - Transmit clock local when set, recovered when clear
// - Per-pair bit inverts that pair's transmit polarity
// - Receive error counter saturates at maximum, never wraps
// - Count every false carrier and symbol error; a false carrier and a symbol error in the same cycle count once
// - Page number selects page; page register on all
// - Gigabit disable removes 1000BASE-T from advertisement
// - 100 Mb disable removes 100BASE-TX from advertisement
// - Disable/reverse bits apply only on three events
// - Reverse bit selects reversed autonegotiation
// - Link-down delay field selects 0/10/20/40 ms
// - Speed-up bit selects fast gigabit link-down
// - Test field selects normal, 112 ns, 16 ns
// - Polarity force bit forces negative receive polarity
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define PCC_IDX_CTRL2 5'h14
`define PCC_IDX_RXERR 5'h15
`define PCC_IDX_PAGE 5'h16
`define PCC_IDX_CTRL3 5'h17
`define PCC_IDX_CMD 5'h19
`define PCC_IDX_IRQ_STAT 5'h1a
`define PCC_IDX_IRQ_MASK 5'h1b
`define PCC_CTRL_PAGE 8'h00

// ============================================================
// Reset values
`define PCC_CTRL2_RST 16'h0020
`define PCC_CTRL2_CLK_POS 5
`define PCC_CTRL3_RST 16'h0000
`define PCC_CTRL3_RSVD_RST 5'h00
`define PCC_RXERR_MAX 16'hffff
`define PCC_PAGE_WMASK 16'hc0ff

// ============================================================
// Command and interrupt bit positions
`define PCC_CMD_SWRST 0
`define PCC_CMD_ANRST 1
`define PCC_IRQ_FCAR 0
`define PCC_IRQ_SYM 1
`define PCC_IRQ_SAT 2
`define PCC_IRQ_W 3

// ============================================================
// Timing
`define PCC_CLK_KHZ 25000
`define PCC_LD_10_MS 10
`define PCC_LD_20_MS 20
`define PCC_LD_40_MS 40

`endif

// ### pcc_pkg.sv
// Types shared by the copper control register bank
package pcc_pkg;

	// Copper control two layout
	typedef struct packed {
		logic [7:0] rsvd;
		logic te_enable;
		logic ipg_keep_link;
		logic tx_clk_local;
		logic accel_link_up;
		logic [3:0] tx_pol_invert;
	} pcc_ctrl2_t;

	// Copper control three layout
	typedef struct packed {
		logic tx_class_a;
		logic dis_1000;
		logic reverse_an;
		logic dis_100;
		logic [1:0] ld_delay;
		logic fast_ld;
		logic [4:0] rsvd;
		logic [1:0] test_sel;
		logic rx_pol_force;
		logic rsvd0;
	} pcc_ctrl3_t;

endpackage

// ### pcc_copper_regs_props.sv
// Concurrent checks on the copper control register bank ports
`timescale 1ns/1ns
module pcc_copper_regs_props (
	input wire logic clock_i, // Clock
	input wire logic reset_n_i, // Reset, active low
	input wire logic read_i, // Bus read
	input wire logic write_i, // Bus write
	input wire logic [31:0] readdata_o, // Read data
	input wire logic waitrequest_o, // Wait request
	input wire logic short_ipg_i, // Short gap seen
	input wire logic link_drop_o, // Link drop
	input wire logic adv_100_full_i, // 100 full advert
	input wire logic adv_100_half_i, // 100 half advert
	input wire logic adv_100_o, // 100 advertised
	input wire logic test_112_o, // Long test sequence
	input wire logic test_16_o, // Short test sequence
	input wire logic an_restart_o, // Autoneg restart
	input wire logic gig_fail_i, // Raw gigabit failure
	input wire logic gig_down_std_i, // Standard verdict
	input wire logic gig_link_down_o // Link-down verdict
);
	// All checks share the one clock domain
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	// ============================================================
	// Bus handshake
	sequence s_req;
		(read_i || write_i) && waitrequest_o;
	endsequence
	sequence s_ans;
		!waitrequest_o ##1 waitrequest_o;
	endsequence
	acc_answer_a: assert property (s_req |=> s_ans)
		else $error("access not answered in one cycle");
	idle_wait_a: assert property (!read_i && !write_i && waitrequest_o |=> waitrequest_o)
		else $error("answer without a request");
	rd_upper_a: assert property (!waitrequest_o |-> readdata_o[31:16] == 16'h0000)
		else $error("upper read data not zero");
	// ============================================================
	// Feature outputs
	link_drop_a: assert property (link_drop_o |-> $past(short_ipg_i))
		else $error("link dropped without short gap");
	adv_100_a: assert property (adv_100_o |-> $past(adv_100_full_i || adv_100_half_i))
		else $error("100 advertised without base advert");
	test_one_a: assert property (!(test_112_o && test_16_o))
		else $error("two test sequences at once");
	an_pulse_a: assert property (an_restart_o |=> !an_restart_o)
		else $error("restart pulse longer than one cycle");
	gig_down_a: assert property (gig_link_down_o |-> $past(gig_fail_i || gig_down_std_i))
		else $error("link down without failure");
endmodule // pcc_copper_regs_props

bind pcc_copper_regs pcc_copper_regs_props i_props (.clock_i, .reset_n_i, .read_i, .write_i,
	.readdata_o, .waitrequest_o, .short_ipg_i, .link_drop_o, .adv_100_full_i, .adv_100_half_i,
	.adv_100_o, .test_112_o, .test_16_o, .an_restart_o, .gig_fail_i, .gig_down_std_i,
	.gig_link_down_o);

// ### pcc_line_model.sv
// Line-side source of false carrier and symbol error events
`timescale 1ns/1ns
module pcc_line_model (
	input wire logic clock_i, // Bench clock
	input wire logic go_i, // Start a burst
	input wire logic [16:0] len_i, // Burst length in cycles
	input wire logic sym_i, // Burst on symbol error line
	output logic false_carrier_o, // False carrier level
	output logic symbol_error_o, // Symbol error level
	output logic busy_o // Burst running
);
	logic [16:0] left_q = 17'h0; // Cycles left
	logic sel_q = 1'b0; // Chosen line
	// ============================================================
	// Burst counter
	always_ff @(posedge clock_i)
	begin
		if (go_i)
		begin
			left_q <= len_i;
			sel_q <= sym_i;
		end
		else if (left_q != 17'h0)
			left_q <= left_q - 17'h1;
	end
	// A held line counts once per cycle, so long bursts are cheap
	assign busy_o = left_q != 17'h0;
	assign false_carrier_o = busy_o & ~sel_q;
	assign symbol_error_o = busy_o & sel_q;
endmodule // pcc_line_model

// ### tb.sv
// Self-checking bench for the copper control register bank
`timescale 1ns/1ns
module tb;
	// ============================================================
	// Signals, most named as the ports they feed
	logic clock_i = 1'b0, reset_n_i = 1'b0; // Clock and reset
	logic read_i = 1'b0, write_i = 1'b0; // Bus strobes
	logic [6:0] address_i = 7'h00; // Bus address
	logic [31:0] writedata_i = 32'h0, readdata_o, q; // Bus data
	logic waitrequest_o, irq_o, link_drop_o, tx_clk_local_o, te_enable_o; // Outputs
	logic accel_link_up_o, adv_1000_o, adv_100_o, reverse_an_o, an_restart_o; // Outputs
	logic gig_link_down_o, tx_class_a_o, test_112_o, test_16_o, rx_pol_force_o; // Outputs
	logic [3:0] tx_pol_invert_o; // Pair inversion
	logic [7:0] page_o; // Page number
	logic false_carrier_i, symbol_error_i, busy, go = 1'b0, lsym = 1'b0; // Line model
	logic [16:0] len = 17'h0; // Burst length
	logic short_ipg_i = 1'b0, power_down_i = 1'b0, gig_fail_i = 1'b0, gig_down_std_i = 1'b0;
	logic [3:0] adv = 4'h0; // Base page adverts
	logic [3:0] be = 4'h3; // Byte lane enables
	logic link_up = 1'b0; // Copper link status
	logic [31:0] seed = 32'h6635; // Random state
	logic [15:0] v; // Random word
	int n_fail = 0, checked = 0; // Counters
	// Short link-down counts keep the run brief
	pcc_copper_regs #(.LD_10_CYC(21'd10), .LD_20_CYC(21'd20), .LD_40_CYC(21'd40)) i_dut (
		.clock_i, .reset_n_i, .address_i, .read_i, .write_i, .byteenable_i(be),
		.writedata_i, .readdata_o, .waitrequest_o, .irq_o, .false_carrier_i, .symbol_error_i,
		.short_ipg_i, .power_down_i, .copper_link_up_i(link_up), .adv_1000_full_i(adv[3]),
		.adv_1000_half_i(adv[2]), .adv_100_full_i(adv[1]), .adv_100_half_i(adv[0]),
		.gig_fail_i, .gig_down_std_i, .link_drop_o, .tx_clk_local_o, .te_enable_o,
		.accel_link_up_o, .tx_pol_invert_o, .adv_1000_o, .adv_100_o, .reverse_an_o,
		.an_restart_o, .gig_link_down_o, .tx_class_a_o, .test_112_o, .test_16_o,
		.rx_pol_force_o, .page_o);
	pcc_line_model i_line (.clock_i, .go_i(go), .len_i(len), .sym_i(lsym),
		.false_carrier_o(false_carrier_i), .symbol_error_o(symbol_error_i), .busy_o(busy));
	// ============================================================
	// Clock and watchdog
	initial
	begin
		forever #20 clock_i = ~clock_i;
	end
	initial
	begin
		repeat (90000) @(posedge clock_i);
		n_fail++;
		summarize();
	end
	// ============================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected feature outputs of a control two value
	function automatic logic [7:0] feat(logic [15:0] w);
		return {w[7], ~w[6], w[5:0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// One bus access, held until waitrequest is seen low
	task automatic acc(input logic w, input logic [6:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clock_i);
		address_i <= a;
		write_i <= w;
		read_i <= !w;
		writedata_i <= {16'h0000, d};
		do
		begin
			@(posedge clock_i);
			n++;
		end
		while (waitrequest_o !== 1'b0 && n < 20);
		if (n >= 20)
		begin
			n_fail++;
			summarize();
		end
		q = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
		acc(1'b0, a, 16'h0);
		chk(q, exp);
	endtask
	// Burst of line events, waited out under a bound
	task automatic fire(input logic s, input logic [16:0] n);
		int k;
		k = 0;
		go <= 1'b1;
		len <= n;
		lsym <= s;
		@(posedge clock_i);
		go <= 1'b0;
		do
		begin
			@(posedge clock_i);
			k++;
		end
		while (busy && k < 70000);
		if (busy)
		begin
			n_fail++;
		end
		cyc(2);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ============================================================
	// Tests
	initial
	begin
		cyc(8);
		reset_n_i <= 1'b1;
		cyc(2);
		rd_chk(7'h50, 32'h20);
		rd_chk(7'h5c, 32'h0);
		chk(tx_clk_local_o, 1'b1);
		chk({adv_1000_o, adv_100_o, reverse_an_o}, 3'b000);
		$display("test reset done");
		short_ipg_i <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			v = 16'(rnd());
			acc(1'b1, 7'h50, v);
			cyc(3);
			chk({te_enable_o, link_drop_o, tx_clk_local_o, accel_link_up_o, tx_pol_invert_o},
				feat(v));
			rd_chk(7'h50, v);
		end
		$display("test control two done");
		for (int t = 0; t < 4; t++)
		begin
			v = {t[0], 6'h0, 5'h4, t[1:0], t[1], 1'b0};
			acc(1'b1, 7'h5c, v);
			cyc(3);
			chk({tx_class_a_o, test_112_o, test_16_o, rx_pol_force_o},
				{t[0], t == 2, t == 3, t[1]});
		end
		$display("test modes done");
		adv <= 4'h9;
		acc(1'b1, 7'h5c, 16'h7040);
		cyc(3);
		chk({adv_1000_o, adv_100_o, reverse_an_o}, 3'b110);
		rd_chk(7'h5c, 32'h7040);
		acc(1'b1, 7'h64, 16'h0002);
		cyc(1);
		chk(an_restart_o, 1'b1);
		cyc(1);
		chk(an_restart_o, 1'b0);
		cyc(1);
		chk({adv_1000_o, adv_100_o, reverse_an_o}, 3'b001);
		acc(1'b1, 7'h5c, 16'h0040);
		power_down_i <= 1'b1;
		cyc(2);
		power_down_i <= 1'b0;
		cyc(4);
		chk({adv_1000_o, adv_100_o, reverse_an_o}, 3'b110);
		acc(1'b1, 7'h5c, 16'h7040);
		link_up <= 1'b1;
		power_down_i <= 1'b1;
		cyc(2);
		power_down_i <= 1'b0;
		cyc(4);
		chk({adv_1000_o, adv_100_o, reverse_an_o}, 3'b110);
		link_up <= 1'b0;
		acc(1'b1, 7'h50, 16'h00c1);
		acc(1'b1, 7'h5c, 16'h0046);
		acc(1'b1, 7'h64, 16'h0001);
		rd_chk(7'h50, 32'h00e1);
		rd_chk(7'h5c, 32'h0006);
		$display("test deferred and soft reset done");
		acc(1'b1, 7'h58, 16'h0003);
		rd_chk(7'h50, 32'h0);
		rd_chk(7'h58, 32'h3);
		chk(page_o, 8'h03);
		acc(1'b1, 7'h50, 16'hffff);
		acc(1'b1, 7'h58, 16'h0000);
		rd_chk(7'h50, 32'h00e1);
		be <= 4'h1;
		acc(1'b1, 7'h50, 16'hff12);
		be <= 4'h2;
		acc(1'b1, 7'h50, 16'hab34);
		be <= 4'h3;
		rd_chk(7'h50, 32'hab12);
		rd_chk(7'h7c, 32'h0);
		$display("test paging done");
		fire(1'b0, 17'd5);
		fire(1'b1, 17'd3);
		chk(irq_o, 1'b0);
		rd_chk(7'h54, 32'h8);
		rd_chk(7'h54, 32'h0);
		acc(1'b1, 7'h6c, 16'h0007);
		cyc(2);
		chk(irq_o, 1'b1);
		acc(1'b1, 7'h68, 16'h0003);
		cyc(2);
		chk(irq_o, 1'b0);
		fire(1'b0, 17'd65540);
		rd_chk(7'h54, 32'hffff);
		rd_chk(7'h68, 32'h5);
		chk(irq_o, 1'b1);
		acc(1'b1, 7'h68, 16'h0005);
		rd_chk(7'h68, 32'h0);
		$display("test counter done");
		for (int k = 0; k < 4; k++)
		begin
			acc(1'b1, 7'h5c, {4'h0, k[1:0], 10'h240});
			gig_fail_i <= 1'b1;
			if (k > 0)
			begin
				cyc(5 * (1 << k) - 1);
				chk(gig_link_down_o, 1'b0);
			end
			cyc(8);
			chk(gig_link_down_o, 1'b1);
			gig_fail_i <= 1'b0;
			cyc(3);
		end
		acc(1'b1, 7'h5c, 16'h0040);
		gig_fail_i <= 1'b1;
		cyc(50);
		chk(gig_link_down_o, 1'b0);
		gig_down_std_i <= 1'b1;
		cyc(3);
		chk(gig_link_down_o, 1'b1);
		$display("test link down done");
		summarize();
	end
endmodule // tb
